/* File: src/bootlk_regs.svh */
// Constants for the boot-lock and configuration-fuse block
`ifndef BOOTLK_REGS_SVH
`define BOOTLK_REGS_SVH

// Lock byte fields
`define BLK_LK_MEM1 0
`define BLK_LK_APP_LO 2
`define BLK_LK_APP_HI 3
`define BLK_LK_BOOT_LO 4
`define BLK_LK_BOOT_HI 5
`define BLK_LOCK_RST 8'h3f
`define BLK_LOCK_ERASE 8'h3f
`define BLK_LOCK_KEEP 8'hc0

// Extended byte fields
`define BLK_EX_RB 5
`define BLK_EX_RVA 4
`define BLK_EX_RVB 3
`define BLK_EXT_RST 8'hff

// High byte fields
`define BLK_HI_EEPROM_KEEP_ON_ERASE 3
`define BLK_HI_BSZ_HI 2
`define BLK_HI_BSZ_LO 1
`define BLK_HI_SERIAL_PROG_ENABLE_MASK 8'h20
`define BLK_HIGH_RST 8'hdf

// Boot section start word per boot size code
`define BLK_BOOT_START_11 15'h7e00
`define BLK_BOOT_START_10 15'h7c00
`define BLK_BOOT_START_01 15'h7800
`define BLK_BOOT_START_00 15'h7000

// Timing windows after arming, in cycles, and the data returned by a blocked read
`define BLK_SPM_WIN 3'h4
`define BLK_LPM_FLOOR 3'h1
`define BLK_BLOCKED_RD 8'hff

`endif

/* File: src/bootlk_pkg.sv */
// Types shared by the boot-lock block
package bootlk_pkg;
  typedef enum logic [1:0] {
    ST_LATCH = 2'b01,
    ST_RUN = 2'b10
  } bootlk_state_t;
endpackage

/* File: src/bootlk_stage_force.sv */
// Reset-time forcing of the power stage outputs
module bootlk_stage_force (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic latch_i,
  input wire logic reset_behaviour_i,
  input wire logic value_a_i,
  input wire logic value_b_i,
  input wire logic poc_wr_i,
  input wire logic [2:0] port_a_i,
  input wire logic [2:0] port_b_i,
  output logic [2:0] stage_out_a_o,
  output logic [2:0] stage_out_b_o,
  output logic forced_o
);
  logic forced_r;
  logic forced_nxt;

  // A config write releases the force even if it lands on the latch cycle
  always_comb begin
    forced_nxt = forced_r;
    if (latch_i) begin
      forced_nxt = !reset_behaviour_i;
    end
    if (poc_wr_i) begin
      forced_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      forced_r <= 1'b0;
    end else begin
      forced_r <= forced_nxt;
    end
  end

  // Outputs follow the port unless forced; fuse 0 means high
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      stage_out_a_o <= 3'h0;
      stage_out_b_o <= 3'h0;
    end else begin
      stage_out_a_o <= forced_nxt ? {3{!value_a_i}} : port_a_i;
      stage_out_b_o <= forced_nxt ? {3{!value_b_i}} : port_b_i;
    end
  end

  assign forced_o = forced_r;

  property p_force_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      forced_r && !poc_wr_i |=> forced_r && stage_out_a_o == {3{!value_a_i}};
  endproperty
  a_force_hold: assert property (p_force_hold) else $error("stage force dropped");
endmodule // bootlk_stage_force

/* File: src/bootlk_core.sv */
// Boot-lock protection, fuse store and latch, core access checking
`include "bootlk_regs.svh"

module bootlk_core (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic core_ld_i,
  input wire logic core_st_i,
  input wire logic [14:0] core_addr_i,
  input wire logic [14:0] core_pc_i,
  input wire logic [7:0] core_st_data_i,
  input wire logic ivec_in_boot_i,
  input wire logic ctrl_wr_i,
  input wire logic ctrl_lock_set_i,
  input wire logic ctrl_store_en_i,
  input wire logic prog_erase_i,
  input wire logic prog_fuse_wr_i,
  input wire logic prog_fuse_sel_i,
  input wire logic prog_lock_wr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic prog_serial_i,
  input wire logic prog_rd_i,
  input wire logic [1:0] prog_rd_sel_i,
  input wire logic poc_wr_i,
  input wire logic [2:0] port_a_i,
  input wire logic [2:0] port_b_i,
  output logic ld_done_o,
  output logic ld_ok_o,
  output logic ld_cfg_o,
  output logic [7:0] ld_data_o,
  output logic st_done_o,
  output logic st_ok_o,
  output logic irq_block_o,
  output logic [2:0] stage_out_a_o,
  output logic [2:0] stage_out_b_o,
  output logic stage_forced_o,
  output logic eeprom_erase_o,
  output logic prog_refused_o,
  output logic [7:0] prog_rdata_o,
  output logic [7:0] ext_cfg_o,
  output logic [7:0] high_cfg_o,
  output logic ready_o
);
  bootlk_pkg::bootlk_state_t state_r;
  // Nonvolatile stores: erased values once at power-up, never touched by reset
  logic [7:0] lock_r = `BLK_LOCK_RST;
  logic [7:0] ext_nv_r = `BLK_EXT_RST;
  logic [7:0] high_nv_r = `BLK_HIGH_RST;
  logic [7:0] ext_lat_r;
  logic [7:0] high_lat_r;
  logic [2:0] win_r;
  logic run;
  logic pc_boot;
  logic tgt_boot;
  logic app_lo;
  logic app_hi;
  logic boot_lo;
  logic boot_hi;
  logic st_block;
  logic ld_block;
  logic cfg_ld;
  logic lock_spm;
  logic arm;
  logic fuse_refused;
  logic [1:0] bsz;
  logic latching;
  logic [7:0] stage_fuse;

  // Word address at or above the boot start lies in the boot section
  function automatic logic in_boot(input logic [14:0] a, input logic [1:0] sz);
    logic [14:0] s;
    unique case (sz)
      2'b11: s = `BLK_BOOT_START_11;
      2'b10: s = `BLK_BOOT_START_10;
      2'b01: s = `BLK_BOOT_START_01;
      2'b00: s = `BLK_BOOT_START_00;
    endcase
    return a >= s;
  endfunction

  // Boot size comes from the latched high byte, not the live fuse
  assign bsz = {high_lat_r[`BLK_HI_BSZ_HI], high_lat_r[`BLK_HI_BSZ_LO]};
  assign run = state_r == bootlk_pkg::ST_RUN;
  assign pc_boot = in_boot(core_pc_i, bsz);
  assign tgt_boot = in_boot(core_addr_i, bsz);
  assign app_lo = lock_r[`BLK_LK_APP_LO];
  assign app_hi = lock_r[`BLK_LK_APP_HI];
  assign boot_lo = lock_r[`BLK_LK_BOOT_LO];
  assign boot_hi = lock_r[`BLK_LK_BOOT_HI];

  // Store protection keys on the low bit of each pair
  assign st_block = tgt_boot ? !boot_lo : !app_lo;

  // Cross-section load protection keys on the high bit of each pair
  always_comb begin
    if (tgt_boot) begin
      ld_block = !pc_boot && !boot_hi;
    end else begin
      ld_block = pc_boot && !app_hi;
    end
  end

  // Arming window after lock-set together with store-enable
  assign arm = ctrl_wr_i && ctrl_lock_set_i && ctrl_store_en_i && run;
  assign cfg_ld = win_r > `BLK_LPM_FLOOR;
  assign lock_spm = core_st_i && run && win_r != 3'h0;
  assign fuse_refused = !lock_r[`BLK_LK_MEM1];

  // Latch after each reset: one cycle copying the fuses, then run
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_r <= bootlk_pkg::ST_LATCH;
    end else begin
      unique case (state_r)
        bootlk_pkg::ST_LATCH: state_r <= bootlk_pkg::ST_RUN;
        bootlk_pkg::ST_RUN: state_r <= bootlk_pkg::ST_RUN;
        default: state_r <= bootlk_pkg::ST_LATCH;
      endcase
    end
  end

  // Later fuse writes do not reach the latched copies until the next reset
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ext_lat_r <= `BLK_EXT_RST;
      high_lat_r <= `BLK_HIGH_RST;
    end else if (state_r == bootlk_pkg::ST_LATCH) begin
      ext_lat_r <= ext_nv_r;
      high_lat_r <= high_nv_r;
    end
  end

  // Window counter; any other control write or a store uses it up
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      win_r <= 3'h0;
    end else if (arm) begin
      win_r <= `BLK_SPM_WIN;
    end else if (ctrl_wr_i || lock_spm) begin
      win_r <= 3'h0;
    end else if (win_r != 3'h0) begin
      win_r <= win_r - 3'h1;
    end
  end

  // Lock bits only move towards programmed except on chip erase; reset must not unlock
  always_ff @(posedge clk_sys_i) begin
    if (prog_erase_i) begin
      lock_r <= lock_r | `BLK_LOCK_ERASE;
    end else if (prog_lock_wr_i) begin
      lock_r <= lock_r & prog_data_i;
    end else if (lock_spm) begin
      lock_r <= lock_r & (core_st_data_i | `BLK_LOCK_KEEP);
    end
  end

  // Fuse store; erase and reset are ignored here so fuses survive both
  always_ff @(posedge clk_sys_i) begin
    if (prog_fuse_wr_i && !fuse_refused && !prog_erase_i) begin
      if (!prog_fuse_sel_i) begin
        ext_nv_r <= prog_data_i;
      end else if (prog_serial_i) begin
        high_nv_r <= (prog_data_i & ~`BLK_HI_SERIAL_PROG_ENABLE_MASK)
                   | (high_nv_r & `BLK_HI_SERIAL_PROG_ENABLE_MASK);
      end else begin
        high_nv_r <= prog_data_i;
      end
    end
  end

  // Programming-side status; the eeprom keep fuse acts without latching
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      eeprom_erase_o <= 1'b0;
      prog_refused_o <= 1'b0;
    end else begin
      eeprom_erase_o <= prog_erase_i && high_nv_r[`BLK_HI_EEPROM_KEEP_ON_ERASE];
      prog_refused_o <= prog_fuse_wr_i && fuse_refused;
    end
  end

  // Programming read-back returns raw bits, 0 meaning programmed, except that serial reads of the high byte show bit 5 as 1
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prog_rdata_o <= 8'h00;
    end else if (prog_rd_i) begin
      unique case (prog_rd_sel_i)
        2'b00: prog_rdata_o <= lock_r;
        2'b01: prog_rdata_o <= ext_nv_r;
        2'b10, 2'b11: prog_rdata_o <= prog_serial_i ?
          (high_nv_r | `BLK_HI_SERIAL_PROG_ENABLE_MASK) : high_nv_r;
      endcase
    end
  end

  // Load answer one cycle after the request; never stalls the core
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ld_done_o <= 1'b0;
      ld_ok_o <= 1'b0;
      ld_cfg_o <= 1'b0;
      ld_data_o <= 8'h00;
    end else begin
      ld_done_o <= core_ld_i;
      ld_cfg_o <= 1'b0;
      ld_ok_o <= 1'b0;
      ld_data_o <= `BLK_BLOCKED_RD;
      if (core_ld_i && run && cfg_ld && !ctrl_wr_i) begin
        ld_cfg_o <= 1'b1;
        ld_ok_o <= 1'b1;
        if (!core_addr_i[0]) begin
          ld_data_o <= lock_r;
        end else begin
          ld_data_o <= core_addr_i[1] ? high_lat_r : ext_lat_r;
        end
      end else if (core_ld_i && run) begin
        ld_ok_o <= !ld_block;
      end
    end
  end

  // Store answer; a lock-set store is always taken
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_done_o <= 1'b0;
      st_ok_o <= 1'b0;
    end else begin
      st_done_o <= core_st_i;
      st_ok_o <= core_st_i && run && (lock_spm || !st_block);
    end
  end

  // Interrupt masking while running from the section that cannot reach vectors
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irq_block_o <= 1'b0;
    end else begin
      irq_block_o <= (!app_hi && ivec_in_boot_i && !pc_boot)
                   || (!boot_hi && !ivec_in_boot_i && pc_boot);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= state_r == bootlk_pkg::ST_LATCH || run;
    end
  end

  // Forced levels come from the store on the latch cycle and from the latched copy after,
  // so a later fuse write cannot move a forced output
  assign latching = state_r == bootlk_pkg::ST_LATCH;
  assign stage_fuse = latching ? ext_nv_r : ext_lat_r;

  assign ext_cfg_o = ext_lat_r;
  assign high_cfg_o = high_lat_r;

  bootlk_stage_force u_stage (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .latch_i(latching),
    .reset_behaviour_i(stage_fuse[`BLK_EX_RB]),
    .value_a_i(stage_fuse[`BLK_EX_RVA]),
    .value_b_i(stage_fuse[`BLK_EX_RVB]),
    .poc_wr_i(poc_wr_i),
    .port_a_i(port_a_i),
    .port_b_i(port_b_i),
    .stage_out_a_o(stage_out_a_o),
    .stage_out_b_o(stage_out_b_o),
    .forced_o(stage_forced_o)
  );

  sequence s_arm;
    ctrl_wr_i && ctrl_lock_set_i && ctrl_store_en_i && run;
  endsequence
  sequence s_plain_ld;
    core_ld_i && !ctrl_wr_i;
  endsequence

  property p_st_app;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      core_st_i && run && !tgt_boot && !app_lo && win_r == 3'h0 |=> st_done_o && !st_ok_o;
  endproperty
  a_st_app: assert property (p_st_app) else $error("app store not blocked");

  property p_ld_to_app;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      core_ld_i && run && pc_boot && !tgt_boot && !app_hi && !cfg_ld |=> !ld_ok_o;
  endproperty
  a_ld_to_app: assert property (p_ld_to_app) else $error("boot load of app passed");

  property p_ld_to_boot;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      core_ld_i && run && !pc_boot && tgt_boot && !boot_hi && !cfg_ld |=> !ld_ok_o;
  endproperty
  a_ld_to_boot: assert property (p_ld_to_boot) else $error("app load of boot passed");

  property p_open;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      core_ld_i && run && &lock_r[5:2] |=> ld_done_o && ld_ok_o;
  endproperty
  a_open: assert property (p_open) else $error("unlocked load refused");

  property p_fuse_lock;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      prog_fuse_wr_i && fuse_refused |=> $stable(ext_nv_r) && $stable(high_nv_r) && prog_refused_o;
  endproperty
  a_fuse_lock: assert property (p_fuse_lock) else $error("locked fuse changed");

  property p_erase;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      prog_erase_i |=> $stable(ext_nv_r) && $stable(high_nv_r) && lock_r[5:0] == 6'h3f;
  endproperty
  a_erase: assert property (p_erase) else $error("erase result wrong");

  property p_cfg_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_arm ##2 s_plain_ld |=> ld_cfg_o && ld_ok_o;
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config load missed");

  property p_irq;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !app_hi && ivec_in_boot_i && !pc_boot |=> irq_block_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupts not masked");

  property p_latch;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      run && prog_fuse_wr_i |=> $stable(ext_cfg_o) && $stable(high_cfg_o);
  endproperty
  a_latch: assert property (p_latch) else $error("latched fuse moved");
endmodule // bootlk_core

/* File: tb/bootlk_core_model.sv */
// Behavioural processor core that issues program-memory loads and stores
module bootlk_core_model (
  input wire logic clk_sys_i,
  input wire logic ld_done_i,
  input wire logic ld_ok_i,
  input wire logic ld_cfg_i,
  input wire logic [7:0] ld_data_i,
  input wire logic st_done_i,
  input wire logic st_ok_i,
  output logic core_ld_o,
  output logic core_st_o,
  output logic [14:0] core_addr_o,
  output logic [14:0] core_pc_o,
  output logic [7:0] core_st_data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle core at time zero
  initial begin
    core_ld_o = 1'b0;
    core_st_o = 1'b0;
    core_addr_o = 15'h0000;
    core_pc_o = 15'h0000;
    core_st_data_o = 8'h00;
  end

  // Entered at a falling edge; the request is taken at the next rising edge
  task automatic access(input logic st, input logic [14:0] addr, input logic [14:0] pc,
      input logic [7:0] data, output logic done, output logic ok, output logic cfg,
      output logic [7:0] rdata);
    core_ld_o = !st;
    core_st_o = st;
    core_addr_o = addr;
    core_pc_o = pc;
    core_st_data_o = data;
    @(negedge clk_sys_i);
    core_ld_o = 1'b0;
    core_st_o = 1'b0;
    // Scrambled when idle so stale address or data never looks valid
    core_addr_o = ~addr;
    core_st_data_o = ~data;
    done = st ? st_done_i : ld_done_i;
    ok = st ? st_ok_i : ld_ok_i;
    cfg = st ? 1'b0 : ld_cfg_i;
    rdata = ld_data_i;
  endtask
endmodule // bootlk_core_model

/* File: tb/tb_top.sv */
// Self-checking bench for the boot-lock and configuration-fuse block
`include "bootlk_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, rstn_i, ivec_in_boot_i, ctrl_wr_i, ctrl_lock_set_i, ctrl_store_en_i;
  logic prog_erase_i, prog_fuse_wr_i, prog_fuse_sel_i, prog_lock_wr_i, prog_serial_i;
  logic prog_rd_i, poc_wr_i, core_ld_i, core_st_i;
  logic [1:0] prog_rd_sel_i;
  logic [7:0] prog_data_i, core_st_data_i, ld_data_o, prog_rdata_o, ext_cfg_o, high_cfg_o;
  logic [2:0] port_a_i, port_b_i, stage_out_a_o, stage_out_b_o;
  logic [14:0] core_addr_i, core_pc_i;
  logic ld_done_o, ld_ok_o, ld_cfg_o, st_done_o, st_ok_o, irq_block_o, stage_forced_o;
  logic eeprom_erase_o, prog_refused_o, ready_o;
  int err_total;
  int total_checks;
  logic ee_seen, ref_seen;

  bootlk_core uut (.clk_sys_i, .rstn_i, .core_ld_i, .core_st_i, .core_addr_i, .core_pc_i,
    .core_st_data_i, .ivec_in_boot_i, .ctrl_wr_i, .ctrl_lock_set_i, .ctrl_store_en_i,
    .prog_erase_i, .prog_fuse_wr_i, .prog_fuse_sel_i, .prog_lock_wr_i, .prog_data_i,
    .prog_serial_i, .prog_rd_i, .prog_rd_sel_i, .poc_wr_i, .port_a_i, .port_b_i,
    .ld_done_o, .ld_ok_o, .ld_cfg_o, .ld_data_o, .st_done_o, .st_ok_o, .irq_block_o,
    .stage_out_a_o, .stage_out_b_o, .stage_forced_o, .eeprom_erase_o, .prog_refused_o,
    .prog_rdata_o, .ext_cfg_o, .high_cfg_o, .ready_o);

  bootlk_core_model core (.clk_sys_i, .ld_done_i(ld_done_o), .ld_ok_i(ld_ok_o),
    .ld_cfg_i(ld_cfg_o), .ld_data_i(ld_data_o), .st_done_i(st_done_o), .st_ok_i(st_ok_o),
    .core_ld_o(core_ld_i), .core_st_o(core_st_i), .core_addr_o(core_addr_i),
    .core_pc_o(core_pc_i), .core_st_data_o(core_st_data_i));

  // 25 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Holds reset for two cycles, then waits a bounded time for ready
  task automatic reset_dut();
    int n;
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    for (n = 0; n < 8 && ready_o !== 1'b1; n++) @(negedge clk_sys_i);
    if (ready_o !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask

  // Programming port: 0 erase, 1 lock write, 2 fuse write, 3 read; sel 00 lock 01 ext 10 high
  task automatic prog(input int op, input logic [1:0] sel, input logic [7:0] data);
    prog_erase_i = (op == 0);
    prog_lock_wr_i = (op == 1);
    prog_fuse_wr_i = (op == 2);
    prog_rd_i = (op == 3);
    prog_fuse_sel_i = sel[1];
    prog_rd_sel_i = sel;
    prog_data_i = data;
    @(negedge clk_sys_i);
    // The status pulses stand for one cycle only, so they are caught here
    ee_seen = eeprom_erase_o;
    ref_seen = prog_refused_o;
    {prog_erase_i, prog_lock_wr_i, prog_fuse_wr_i, prog_rd_i} = 4'h0;
    @(negedge clk_sys_i);
  endtask

  // Arms the configuration read window through the store-control register
  task automatic arm();
    {ctrl_wr_i, ctrl_lock_set_i, ctrl_store_en_i} = 3'b111;
    @(negedge clk_sys_i);
    ctrl_wr_i = 1'b0;
  endtask

  // Allowed outcome of an access; m holds boot hi, boot lo, app hi, app lo
  function automatic logic exp_ok(input logic st, input logic [14:0] a,
      input logic [14:0] pc, input logic [3:0] m);
    logic ab;
    logic pb;
    ab = (a >= `BLK_BOOT_START_11);
    pb = (pc >= `BLK_BOOT_START_11);
    if (st) return ab ? m[2] : m[0];
    return ab ? (pb | m[3]) : (!pb | m[1]);
  endfunction

  initial begin
    logic done, ok, cfg, st, pb, e;
    logic [7:0] d;
    logic [14:0] a, pc;
    logic [3:0] m;
    int i;
    {ivec_in_boot_i, ctrl_wr_i, ctrl_lock_set_i, ctrl_store_en_i} = 4'h0;
    {prog_erase_i, prog_fuse_wr_i, prog_fuse_sel_i, prog_lock_wr_i, prog_serial_i} = 5'h00;
    {prog_rd_i, poc_wr_i, prog_rd_sel_i, prog_data_i, port_a_i, port_b_i} = 18'h00000;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'h9a6c1c7c));
    reset_dut();
    chk("ext_cfg", 8'hff, ext_cfg_o);
    chk("high_cfg", 8'hdf, high_cfg_o);
    // Every lock mode four times, with section boundary addresses among random ones
    for (i = 0; i < 64; i++) begin
      m = i[3:0];
      prog(0, 2'b00, 8'h00);
      prog(1, 2'b00, {2'b11, m, 2'b11});
      st = 1'($urandom_range(0, 1));
      a = (i[5:4] == 0) ? 15'h7dff : (i[5:4] == 1) ? 15'h7e00 : 15'($urandom());
      pc = 15'($urandom());
      pb = (pc >= `BLK_BOOT_START_11);
      ivec_in_boot_i = 1'($urandom_range(0, 1));
      e = exp_ok(st, a, pc, m);
      core.access(st, a, pc, 8'h5a, done, ok, cfg, d);
      chk("done", 8'h01, {7'h00, done});
      chk("ok", {7'h00, e}, {7'h00, ok});
      if (!st) chk("ld_data", 8'hff, d);
      @(negedge clk_sys_i);
      chk("irq_block", {7'h00, ivec_in_boot_i ? (!m[1] && !pb) : (!m[3] && pb)},
        {7'h00, irq_block_o});
    end
    // Config reads from boot code while boot-to-app loads are blocked, then a late load
    prog(0, 2'b00, 8'h00);
    prog(1, 2'b00, 8'hd7);
    for (i = 0; i < 4; i++) begin
      arm();
      // Loads land one, two, three and four cycles after arming
      repeat (i) @(negedge clk_sys_i);
      a = (i == 1) ? 15'h0001 : (i == 2) ? 15'h0003 : 15'h0000;
      core.access(1'b0, a, 15'h7f00, 8'h00, done, ok, cfg, d);
      chk("cfg_flag", {7'h00, i != 3}, {7'h00, cfg});
      chk("cfg_ok", {7'h00, i != 3}, {7'h00, ok});
      chk("cfg_data", (i == 0) ? 8'h17 : (i == 2) ? 8'hdf : 8'hff, d);
    end
    // Lock-set store from software, then an application store is refused
    prog(0, 2'b00, 8'h00);
    arm();
    core.access(1'b1, 15'h0000, 15'h7f00, 8'hfb, done, ok, cfg, d);
    chk("lockset_ok", 8'h01, {7'h00, ok});
    @(negedge clk_sys_i);
    core.access(1'b1, 15'h0100, 15'h0200, 8'h00, done, ok, cfg, d);
    chk("app_store", 8'h00, {7'h00, ok});
    prog(3, 2'b00, 8'h00);
    chk("lock_rd", 8'h3b, prog_rdata_o);
    // Fuse writes, serial hiding, erase, latching and the memory-lock refusal
    prog(0, 2'b00, 8'h00);
    chk("ee_erase", 8'h01, {7'h00, ee_seen});
    prog(2, 2'b01, 8'hc7);
    chk("refused", 8'h00, {7'h00, ref_seen});
    prog(3, 2'b01, 8'h00);
    chk("ext_rd", 8'hc7, prog_rdata_o);
    chk("ext_latched", 8'hff, ext_cfg_o);
    prog_serial_i = 1'b1;
    prog(2, 2'b10, 8'h00);
    prog(3, 2'b10, 8'h00);
    chk("serial_rd", 8'h20, prog_rdata_o);
    prog_serial_i = 1'b0;
    prog(0, 2'b00, 8'h00);
    chk("ee_keep", 8'h00, {7'h00, ee_seen});
    prog(3, 2'b01, 8'h00);
    chk("ext_erase", 8'hc7, prog_rdata_o);
    prog(1, 2'b00, 8'hfe);
    prog(2, 2'b01, 8'hff);
    chk("refused", 8'h01, {7'h00, ref_seen});
    prog(3, 2'b01, 8'h00);
    chk("ext_locked", 8'hc7, prog_rdata_o);
    // Unforced stage outputs follow the ports one cycle later
    for (i = 0; i < 8; i++) begin
      port_a_i = 3'($urandom());
      port_b_i = 3'($urandom());
      poc_wr_i = (i == 4);
      @(negedge clk_sys_i);
      chk("stage_a", {5'h00, port_a_i}, {5'h00, stage_out_a_o});
      chk("stage_b", {5'h00, port_b_i}, {5'h00, stage_out_b_o});
      chk("forced", 8'h00, {7'h00, stage_forced_o});
    end
    // Reset keeps the programmed fuses: behaviour, A and B value all programmed
    reset_dut();
    chk("ext_latch", 8'hc7, ext_cfg_o);
    chk("high_latch", 8'h00, high_cfg_o);
    chk("force_a", 8'h07, {5'h00, stage_out_a_o});
    chk("force_b", 8'h07, {5'h00, stage_out_b_o});
    chk("force_on", 8'h01, {7'h00, stage_forced_o});
    @(negedge clk_sys_i);
    chk("force_hold", 8'h07, {5'h00, stage_out_a_o});
    // The first output-config write releases the force
    poc_wr_i = 1'b1;
    @(negedge clk_sys_i);
    poc_wr_i = 1'b0;
    chk("release_a", {5'h00, port_a_i}, {5'h00, stage_out_a_o});
    chk("release_b", {5'h00, port_b_i}, {5'h00, stage_out_b_o});
    chk("force_off", 8'h00, {7'h00, stage_forced_o});
    finish_test();
  end
endmodule // tb_top
